//--- src/stepper_cmd_regs.svh
`ifndef STEPPER_CMD_REGS_SVH
`define STEPPER_CMD_REGS_SVH

// ****************************************************************
// Output data image: word indices
// ****************************************************************
`define IDX_MOTION      4'h0
`define IDX_AXIS        4'h1
`define IDX_PRESET_HI   4'h2
`define IDX_PRESET_LO   4'h3
`define IDX_DWELL       4'h9
`define IDX_LAST        4'h9

// ****************************************************************
// Motion request word bit positions
// ****************************************************************
`define MR_MODE         15
`define MR_PRESET_ENC   14
`define MR_ASM_RUN      13
`define MR_ASM_READ     12
`define MR_ASM_PROG     11
`define MR_RESET_ERR    10
`define MR_PRESET_POS   9
`define MR_RUN_CCW      8
`define MR_RUN_CW       7
`define MR_SEEK_CCW     6
`define MR_SEEK_CW      5
`define MR_STOP         4
`define MR_RESUME       3
`define MR_HOLD         2
`define MR_REL          1
`define MR_ABS          0

// ****************************************************************
// Axis control word bit positions
// ****************************************************************
`define AC_ENABLE       15
`define AC_ENC_FOLLOW   14
`define AC_AUX_OUT      13
`define AC_POS_FOLLOW   12
`define AC_PROX         11
`define AC_CLR_FAULT    10
`define AC_DWELL        9
`define AC_REGISTRATION 7
`define AC_GEARING      6
`define AC_BLEND_CCW    4

// ****************************************************************
// Status word 0
// ****************************************************************
`define STAT_UNCONFIGURED 16'h6408
`define ST_CFG_ERR      13
`define ST_CMD_ERR      12
`define ST_POS_INVALID  11
`define ST_MOVING       5
`define ST_HELD         4
`define ST_MOVE_DONE    3

`endif

//--- src/stepper_cmd_pkg.sv
package stepper_cmd_pkg;

  // One-cycle action requests towards the motion engine
  typedef struct packed {
    logic abs_move;
    logic rel_move;
    logic hold;
    logic resume;
    logic stop;
    logic seek_ccw;
    logic seek_cw;
    logic run_ccw;
    logic run_cw;
    logic registration;
    logic follower;
    logic preset_motor;
    logic preset_encoder;
    logic clear_errors;
    logic clear_drive_fault;
    logic asm_run;
    logic asm_program;
    logic asm_read;
    logic hold_cancel;
  } cmd_pulse_t;

  // Levels that steer the drive from the axis control word
  typedef struct packed {
    logic motor_enable;
    logic aux_output_level;
    logic gearing;
    logic gear_follow;
    logic dwell_mode;
    logic blend_ccw;
    logic encoder_loop;
    logic motor_loop;
  } axis_ctl_t;

  typedef enum logic [1:0] {
    MOTION_IDLE,
    MOTION_MOVING,
    MOTION_HELD
  } motion_state_t;

endpackage : stepper_cmd_pkg

//--- src/home_input_qualifier.sv
`include "stepper_cmd_regs.svh"

module home_input_qualifier (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_home_pin,
  input  wire logic i_prox_enable,
  input  wire logic i_prox_bit,
  output logic      o_home_level,
  output logic      o_home_edge
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic allow;
  logic [2:0] warm_q;

  // ****************************************************************
  // Two-stage synchroniser, first stage read by the second only
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      sync1_q <= i_home_pin;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  // Edges wait until last_q holds a real pin sample, so a pin that
  // idles high gives no false edge after reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      warm_q <= 3'h0;
    end else begin
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  // Home input is masked while proximity qualifying is enabled and the network proximity bit is low
  assign allow = !i_prox_enable || i_prox_bit;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_home_level <= 1'b0;
      o_home_edge  <= 1'b0;
    end else begin
      o_home_level <= sync2_q && allow;
      o_home_edge  <= sync2_q && !last_q && allow && warm_q[2];
    end
  end

  home_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_prox_enable && !i_prox_bit) |=> !o_home_edge)
    else $error("home edge passed while proximity bit low");

endmodule : home_input_qualifier

//--- src/stepper_command_word_decoder.sv
`include "stepper_cmd_regs.svh"

// What this block does
// - Motion word bit 15 picks configuration mode
// - Unconfigured: status 6408h, no motor, no commands
// - Bit 14 presets encoder from words 2,3
// - Bit 13 runs assembled move; dwell, direction
// - Bits 11,12 program and read assembled segments
// - Bit 10 clears errors, done, reruns command
// - Bit 9 presets motor position, clears done
// - Bits 8,7 start CCW and CW jogs
// - Axis bit 7 makes jog a registration move
// - Gearing follows encoder only while jog set
// - Follower bits turn jog into axis follower
// - Bits 6,5 seek home CCW and CW
// - Bit 4 stops; invalid position if moving or held
// - Bit 3 resumes; new move cancels hold
// - Bit 2 holds current move, resumable
// - Bits 1,0 start relative and absolute moves
// - Axis bit 15 enables current, needs configuration
// - Encoder loop needs encoder; never both loops
// - Axis bit 13 drives general purpose output
// - Proximity bit gates home input
// - Bit 10 with axis bit 10 clears faults while motor disabled
// - Commands act only on zero-to-one transitions, except bits rerun by bit 10
// - Ten sixteen-bit output and input words
module stepper_command_word_decoder (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_wr_valid,
  input  wire logic [3:0]                 i_wr_index,
  input  wire logic [15:0]                i_wr_data,
  input  wire logic                       i_config_valid,
  input  wire logic                       i_cfg_encoder_fb,
  input  wire logic                       i_cfg_gp_output,
  input  wire logic                       i_cfg_prox_qualifier,
  input  wire logic                       i_move_done,
  input  wire logic                       i_home_pin,
  output stepper_cmd_pkg::cmd_pulse_t     o_pulse,
  output stepper_cmd_pkg::axis_ctl_t      o_ctl,
  output logic [31:0]                     o_preset_value,
  output logic [15:0]                     o_dwell_ms,
  output logic [15:0]                     o_status_word0,
  output logic                            o_home_level,
  output logic                            o_home_edge
);

  // ****************************************************************
  // Output data image
  // ****************************************************************
  logic [15:0]                   motion_q;
  logic [15:0]                   axis_q;
  logic [15:0]                   preset_hi_q;
  logic [15:0]                   preset_lo_q;
  logic [15:0]                   dwell_q;
  logic                          wr_motion;
  logic [15:0]                   rise;
  logic                          accept;
  logic [15:0]                   go;
  logic                          jog_go;
  logic                          follow_req;
  logic                          follow_bad;
  logic                          start_move;
  logic                          hold_ok;
  logic                          resume_ok;
  logic                          pos_inval_set;
  logic                          done_clear;
  logic                          cmd_err_q;
  logic                          pos_invalid_q;
  logic                          move_done_q;
  stepper_cmd_pkg::motion_state_t state_q;

  assign wr_motion = i_wr_valid && (i_wr_index == `IDX_MOTION);

  // The image is the same ten words in either mode; only the motion
  // word and the words this block uses are held here.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      motion_q    <= 16'h0000;
      axis_q      <= 16'h0000;
      preset_hi_q <= 16'h0000;
      preset_lo_q <= 16'h0000;
      dwell_q     <= 16'h0000;
    end else if (i_wr_valid && (i_wr_index <= `IDX_LAST)) begin
      if (i_wr_index == `IDX_MOTION) begin
        motion_q <= i_wr_data;
      end else if (i_wr_index == `IDX_AXIS) begin
        axis_q <= i_wr_data;
      end else if (i_wr_index == `IDX_PRESET_HI) begin
        preset_hi_q <= i_wr_data;
      end else if (i_wr_index == `IDX_PRESET_LO) begin
        preset_lo_q <= i_wr_data;
      end else if (i_wr_index == `IDX_DWELL) begin
        dwell_q <= i_wr_data;
      end
    end
  end

  // ****************************************************************
  // Command acceptance
  // ****************************************************************
  // The previous word is kept even across configuration-mode writes,
  // so a bit already set when the mode flips back does not fire.
  assign rise   = i_wr_data & ~motion_q;
  assign accept = wr_motion && !i_wr_data[`MR_MODE]
                  && i_config_valid;

  // An error reset retries whatever move bits are present right now
  always_comb begin
    go = 16'h0000;
    if (accept) begin
      go = rise;
      if (rise[`MR_RESET_ERR]) begin
        go = rise | (i_wr_data & ~(16'h0001 << `MR_RESET_ERR));
      end
    end
  end

  assign jog_go     = go[`MR_RUN_CCW] || go[`MR_RUN_CW];
  assign follow_req = jog_go && !axis_q[`AC_REGISTRATION]
                      && (axis_q[`AC_ENC_FOLLOW]
                          || axis_q[`AC_POS_FOLLOW]);
  // Both loops, or an encoder loop with no encoder, is refused
  assign follow_bad = follow_req
                      && ((axis_q[`AC_ENC_FOLLOW] && axis_q[`AC_POS_FOLLOW])
                          || (axis_q[`AC_ENC_FOLLOW]
                              && !i_cfg_encoder_fb));
  assign start_move = go[`MR_ABS] || go[`MR_REL] || go[`MR_SEEK_CCW]
                      || go[`MR_SEEK_CW] || go[`MR_ASM_RUN]
                      || (jog_go && !follow_bad);
  assign hold_ok    = go[`MR_HOLD]
                      && (state_q == stepper_cmd_pkg::MOTION_MOVING);
  assign resume_ok  = go[`MR_RESUME]
                      && (state_q == stepper_cmd_pkg::MOTION_HELD);
  assign pos_inval_set = go[`MR_STOP]
                         && (state_q != stepper_cmd_pkg::MOTION_IDLE);
  assign done_clear = go[`MR_RESET_ERR] || go[`MR_PRESET_POS];

  // ****************************************************************
  // Action pulses
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pulse <= '0;
    end else begin
      o_pulse.abs_move       <= go[`MR_ABS];
      o_pulse.rel_move       <= go[`MR_REL];
      o_pulse.hold           <= hold_ok;
      o_pulse.resume         <= resume_ok;
      o_pulse.stop           <= go[`MR_STOP];
      o_pulse.seek_ccw       <= go[`MR_SEEK_CCW];
      o_pulse.seek_cw        <= go[`MR_SEEK_CW];
      // A follower request replaces the jog, so no run pulse goes out
      o_pulse.run_ccw        <= go[`MR_RUN_CCW] && !follow_req;
      o_pulse.run_cw         <= go[`MR_RUN_CW] && !follow_req;
      o_pulse.registration   <= jog_go
                                && axis_q[`AC_REGISTRATION];
      o_pulse.follower       <= follow_req && !follow_bad;
      o_pulse.preset_motor   <= go[`MR_PRESET_POS];
      o_pulse.preset_encoder <= go[`MR_PRESET_ENC];
      o_pulse.clear_errors   <= go[`MR_RESET_ERR];
      o_pulse.clear_drive_fault <= go[`MR_RESET_ERR]
                                   && axis_q[`AC_CLR_FAULT]
                                   && !o_ctl.motor_enable;
      o_pulse.asm_run        <= go[`MR_ASM_RUN];
      o_pulse.asm_program    <= go[`MR_ASM_PROG];
      o_pulse.asm_read       <= go[`MR_ASM_READ];
      o_pulse.hold_cancel    <= start_move && (state_q ==
                                stepper_cmd_pkg::MOTION_HELD);
    end
  end

  // Preset value and dwell time are captured with the command so a
  // later rewrite of words 2, 3 or 9 cannot disturb it mid-action.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_preset_value <= 32'h0000_0000;
      o_dwell_ms     <= 16'h0000;
    end else begin
      if (go[`MR_PRESET_POS] || go[`MR_PRESET_ENC]) begin
        o_preset_value <= {preset_hi_q, preset_lo_q};
      end
      if (go[`MR_ASM_RUN]) begin
        o_dwell_ms <= dwell_q;
      end
    end
  end

  // ****************************************************************
  // Motion state
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q <= stepper_cmd_pkg::MOTION_IDLE;
    end else begin
      case (state_q)
        stepper_cmd_pkg::MOTION_IDLE: begin
          if (start_move) begin
            state_q <= stepper_cmd_pkg::MOTION_MOVING;
          end
        end
        stepper_cmd_pkg::MOTION_MOVING: begin
          if (go[`MR_STOP]) begin
            state_q <= stepper_cmd_pkg::MOTION_IDLE;
          end else if (hold_ok) begin
            state_q <= stepper_cmd_pkg::MOTION_HELD;
          end else if (i_move_done && !start_move) begin
            state_q <= stepper_cmd_pkg::MOTION_IDLE;
          end
        end
        stepper_cmd_pkg::MOTION_HELD: begin
          if (go[`MR_STOP]) begin
            state_q <= stepper_cmd_pkg::MOTION_IDLE;
          end else if (resume_ok || start_move) begin
            state_q <= stepper_cmd_pkg::MOTION_MOVING;
          end
        end
        default: begin
          state_q <= stepper_cmd_pkg::MOTION_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sticky flags; a new event beats a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cmd_err_q <= 1'b0;
    end else if (follow_bad) begin
      cmd_err_q <= 1'b1;
    end else if (go[`MR_RESET_ERR]) begin
      cmd_err_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      pos_invalid_q <= 1'b0;
    end else if (pos_inval_set) begin
      pos_invalid_q <= 1'b1;
    end else if (go[`MR_PRESET_POS]) begin
      pos_invalid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      move_done_q <= 1'b0;
    end else if (i_move_done) begin
      move_done_q <= 1'b1;
    end else if (done_clear) begin
      move_done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Axis control levels
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_ctl <= '0;
    end else begin
      o_ctl.motor_enable     <= axis_q[`AC_ENABLE]
                                && i_config_valid;
      o_ctl.aux_output_level <= axis_q[`AC_AUX_OUT]
                                && i_cfg_gp_output;
      o_ctl.gearing          <= axis_q[`AC_GEARING];
      o_ctl.gear_follow      <= axis_q[`AC_GEARING] && i_config_valid
                                && (motion_q[`MR_RUN_CCW]
                                    || motion_q[`MR_RUN_CW]);
      o_ctl.dwell_mode       <= axis_q[`AC_DWELL];
      o_ctl.blend_ccw        <= axis_q[`AC_BLEND_CCW];
      o_ctl.encoder_loop     <= axis_q[`AC_ENC_FOLLOW]
                                && !axis_q[`AC_POS_FOLLOW]
                                && i_cfg_encoder_fb;
      o_ctl.motor_loop       <= axis_q[`AC_POS_FOLLOW]
                                && !axis_q[`AC_ENC_FOLLOW];
    end
  end

  // ****************************************************************
  // Status word 0
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_status_word0 <= `STAT_UNCONFIGURED;
    end else if (!i_config_valid) begin
      o_status_word0 <= `STAT_UNCONFIGURED;
    end else begin
      o_status_word0 <= 16'h0000;
      o_status_word0[`ST_CMD_ERR]     <= cmd_err_q;
      o_status_word0[`ST_POS_INVALID] <= pos_invalid_q;
      o_status_word0[`ST_MOVING]      <=
        (state_q == stepper_cmd_pkg::MOTION_MOVING);
      o_status_word0[`ST_HELD]        <=
        (state_q == stepper_cmd_pkg::MOTION_HELD);
      o_status_word0[`ST_MOVE_DONE]   <= move_done_q;
    end
  end

  // ****************************************************************
  // Home input
  // ****************************************************************
  home_input_qualifier home_qual (
    .i_clock       (i_clock),
    .i_rst_b       (i_rst_b),
    .i_home_pin    (i_home_pin),
    .i_prox_enable (i_cfg_prox_qualifier),
    .i_prox_bit    (axis_q[`AC_PROX]),
    .o_home_level  (o_home_level),
    .o_home_edge   (o_home_edge)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  unconfig_status_a: assert property (
    !i_config_valid |=> o_status_word0 == `STAT_UNCONFIGURED)
    else $error("status not 6408h while unconfigured");

  no_motor_a: assert property (
    !i_config_valid |=> !o_ctl.motor_enable)
    else $error("motor enabled without configuration");

  mode_blocks_a: assert property (
    (wr_motion && i_wr_data[`MR_MODE]) |=> !o_pulse.abs_move
      && !o_pulse.rel_move && !o_pulse.stop)
    else $error("command taken in configuration mode");

  level_no_repeat_a: assert property (
    (wr_motion && motion_q[`MR_ABS] && i_wr_data[`MR_ABS]
     && !i_wr_data[`MR_RESET_ERR]) |=> !o_pulse.abs_move)
    else $error("absolute move without a rising edge");

  abs_start_a: assert property (
    (accept && !motion_q[`MR_ABS] && i_wr_data[`MR_ABS])
      |=> o_pulse.abs_move ##1 (!o_pulse.abs_move || $past(wr_motion)))
    else $error("absolute move pulse missing");

  preset_value_a: assert property (
    go[`MR_PRESET_POS] |=> o_pulse.preset_motor
      && o_preset_value == {$past(preset_hi_q), $past(preset_lo_q)})
    else $error("motor preset value wrong");

  stop_invalid_a: assert property (
    (go[`MR_STOP] && state_q == stepper_cmd_pkg::MOTION_IDLE
     && !pos_invalid_q) |=> !pos_invalid_q)
    else $error("idle stop marked position invalid");

  stop_moving_a: assert property (
    (go[`MR_STOP] && state_q == stepper_cmd_pkg::MOTION_MOVING)
      |=> pos_invalid_q && state_q == stepper_cmd_pkg::MOTION_IDLE)
    else $error("stop during move not flagged");

  hold_cancel_a: assert property (
    (go[`MR_ABS] && state_q == stepper_cmd_pkg::MOTION_HELD
     && !go[`MR_STOP]) |=> o_pulse.hold_cancel
      && state_q == stepper_cmd_pkg::MOTION_MOVING)
    else $error("held move not cancelled by new move");

  follow_refuse_a: assert property (
    follow_bad |=> !o_pulse.follower && cmd_err_q)
    else $error("bad follower request accepted");

  done_clear_a: assert property (
    (go[`MR_RESET_ERR] && !i_move_done && !follow_bad)
      |=> !move_done_q && !cmd_err_q)
    else $error("error reset left flags set");

  fault_clear_a: assert property (
    o_pulse.clear_drive_fault |-> !$past(o_ctl.motor_enable))
    else $error("drive fault clear while enabled");

  aux_out_a: assert property (
    !i_cfg_gp_output |=> !o_ctl.aux_output_level)
    else $error("aux output driven when not general purpose");

  cover_abs_c: cover property (o_pulse.abs_move);
  cover_hold_c: cover property (
    o_pulse.hold ##[1:20] o_pulse.resume);
  cover_follow_c: cover property (o_pulse.follower);
  cover_stop_c: cover property (pos_inval_set);

endmodule : stepper_command_word_decoder

//--- tb/fieldbus_host_model.sv
module fieldbus_host_model (
  input  wire logic        i_clock,
  output logic             o_wr_valid,
  output logic [3:0]       o_wr_index,
  output logic [15:0]      o_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Cyclic writer of the output data image
  // ****************************************
  initial begin
    o_wr_valid = 1'b0;
    o_wr_index = 4'h0;
    o_wr_data  = 16'h0000;
  end
  // One word per strobe, any index 0 to 15
  task automatic put(input logic [3:0] idx, input logic [15:0] d);
    @(posedge i_clock);
    o_wr_valid <= 1'b1;
    o_wr_index <= idx;
    o_wr_data  <= d;
    @(posedge i_clock);
    o_wr_valid <= 1'b0;
    // Idle data is inverted so a stale word cannot pass for a new one
    o_wr_data  <= ~d;
  endtask : put
endmodule : fieldbus_host_model

//--- tb/stepper_command_word_decoder_tb.sv
module stepper_command_word_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0, i_rst_b = 1'b0, cfg = 1'b0, done = 1'b0, pin = 1'b0;
  logic enc = 1'b1, gpo = 1'b1, prox = 1'b1;
  stepper_cmd_pkg::cmd_pulse_t pulse, acc;
  stepper_cmd_pkg::axis_ctl_t  ctl;
  logic [31:0] preset;
  logic [15:0] dwell, status, wr_data;
  logic [3:0]  wr_index;
  logic        wr_valid, hlev, hedge;
  int          miscompares = 0, cmp_count = 0, cycles = 0;
  logic [15:0] wt[10] = '{16'h0001, 16'h0002, 16'h0020, 16'h0040, 16'h0080,
    16'h0100, 16'h0800, 16'h1000, 16'h4000, 16'h0010};
  logic [18:0] pt[10] = '{19'h40000, 19'h20000, 19'h01000, 19'h02000,
    19'h00400, 19'h00800, 19'h00004, 19'h00002, 19'h00040, 19'h04000};
  always #20 i_clock = ~i_clock;
  fieldbus_host_model host (.i_clock(i_clock), .o_wr_valid(wr_valid),
    .o_wr_index(wr_index), .o_wr_data(wr_data));
  stepper_command_word_decoder dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_wr_valid(wr_valid), .i_wr_index(wr_index), .i_wr_data(wr_data),
    .i_config_valid(cfg), .i_cfg_encoder_fb(enc), .i_cfg_gp_output(gpo),
    .i_cfg_prox_qualifier(prox), .i_move_done(done), .i_home_pin(pin),
    .o_pulse(pulse), .o_ctl(ctl), .o_preset_value(preset),
    .o_dwell_ms(dwell), .o_status_word0(status), .o_home_level(hlev),
    .o_home_edge(hedge));
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    host.put(i, d);
    acc = '0;
    repeat (4) begin
      @(negedge i_clock);
      acc = acc | pulse;
    end
  endtask : wr
  // Zero first so every command bit sees a fresh rising edge
  task automatic cmd(input logic [15:0] d, input logic [18:0] e);
    wr(4'h0, 16'h0000);
    wr(4'h0, d);
    chk("o_pulse", 32'(acc), 32'(e));
  endtask : cmd
  task automatic home(input logic v, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge i_clock);
    pin <= v;
    repeat (6) begin
      @(negedge i_clock);
      seen = seen | hedge;
    end
    chk("o_home_edge", 32'(seen), 32'(e));
    chk("o_home_level", 32'(hlev), 32'(v && e));
  endtask : home
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(negedge i_clock);
    chk("o_status_word0", 32'(status), 32'h6408);
    wr(4'h1, 16'h8000);
    cmd(16'h0001, 19'h0);
    chk("motor_enable", 32'(ctl.motor_enable), 32'h0);
    @(posedge i_clock);
    cfg <= 1'b1;
    cmd(16'h8001, 19'h0);
    wr(4'h0, 16'h0001);
    chk("o_pulse", 32'(acc), 32'h0);
    cmd(16'h0001, 19'h40000);
    chk("o_status_word0", 32'(status), 32'h0020);
    chk("motor_enable", 32'(ctl.motor_enable), 32'h1);
    cmd(16'h0004, 19'h10000);
    cmd(16'h0001, 19'h40001);
    cmd(16'h0004, 19'h10000);
    cmd(16'h0008, 19'h08000);
    @(posedge i_clock);
    done <= 1'b1;
    @(posedge i_clock);
    done <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk("o_status_word0", 32'(status), 32'h0008);
    cmd(16'h0004, 19'h0);
    cmd(16'h0010, 19'h04000);
    chk("pos_invalid", 32'(status[11]), 32'h0);
    for (int k = 0; k < 10; k++) cmd(wt[k], pt[k]);
    chk("pos_invalid", 32'(status[11]), 32'h1);
    wr(4'h2, 16'h1234);
    wr(4'h3, 16'h5678);
    cmd(16'h0200, 19'h00080);
    chk("o_preset_value", preset, 32'h12345678);
    chk("move_done", 32'(status[3]), 32'h0);
    wr(4'h1, 16'h8210);
    wr(4'h9, 16'h00c8);
    cmd(16'h2000, 19'h00008);
    chk("o_dwell_ms", 32'(dwell), 32'h00c8);
    chk("dwell_mode", 32'(ctl.dwell_mode), 32'h1);
    chk("blend_ccw", 32'(ctl.blend_ccw), 32'h1);
    wr(4'h1, 16'h0080);
    cmd(16'h0080, 19'h00600);
    wr(4'h1, 16'h1000);
    cmd(16'h0100, 19'h00100);
    chk("motor_loop", 32'(ctl.motor_loop), 32'h1);
    wr(4'h1, 16'h5000);
    cmd(16'h0100, 19'h0);
    chk("cmd_error", 32'(status[12]), 32'h1);
    chk("encoder_loop", 32'(ctl.encoder_loop), 32'h0);
    @(posedge i_clock);
    enc <= 1'b0;
    wr(4'h1, 16'h4000);
    cmd(16'h0100, 19'h0);
    chk("encoder_loop", 32'(ctl.encoder_loop), 32'h0);
    @(posedge i_clock);
    enc <= 1'b1;
    cmd(16'h0100, 19'h00100);
    chk("encoder_loop", 32'(ctl.encoder_loop), 32'h1);
    wr(4'h1, 16'h0400);
    cmd(16'h0400, 19'h00030);
    chk("cmd_error", 32'(status[12]), 32'h0);
    wr(4'h0, 16'h0001);
    wr(4'h0, 16'h0401);
    chk("o_pulse", 32'(acc), 32'h40030);
    wr(4'h1, 16'h2040);
    wr(4'h0, 16'h0080);
    chk("gear_follow", 32'(ctl.gear_follow), 32'h1);
    chk("gearing", 32'(ctl.gearing), 32'h1);
    chk("aux_output_level", 32'(ctl.aux_output_level), 32'h1);
    wr(4'h0, 16'h0000);
    chk("gear_follow", 32'(ctl.gear_follow), 32'h0);
    @(posedge i_clock);
    gpo <= 1'b0;
    repeat (2) @(negedge i_clock);
    chk("aux_output_level", 32'(ctl.aux_output_level), 32'h0);
    home(1'b1, 1'b0);
    home(1'b0, 1'b0);
    wr(4'h1, 16'h0800);
    home(1'b1, 1'b1);
    home(1'b0, 1'b0);
    @(posedge i_clock);
    prox <= 1'b0;
    wr(4'h1, 16'h0000);
    home(1'b1, 1'b1);
    end_of_test();
  end
endmodule : stepper_command_word_decoder_tb
